/* File: src/mie_alu.sv */
`timescale 1ns/100ps
`include "mie_consts.svh"
module mie_alu
  import mie_pkg::*;
(
  // operands
  input  wire logic [`MIE_DW-1:0] opA,
  input  wire logic [`MIE_DW-1:0] opB,
  input  wire logic               carryIn,
  input  wire mie_aluop_e         aluOp,
  // results
  output logic [`MIE_DW-1:0]      result,
  output logic                    carryOut,
  output logic                    auxCarry,
  output logic                    overflow
);
  // ==========================================================
  // add and and
  always_comb
  begin
    logic [`MIE_DW:0] sum;
    logic [4:0]       lowSum;
    sum      = {1'b0, opA} + {1'b0, opB} + {{`MIE_DW{1'b0}}, carryIn};
    lowSum   = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
    carryOut = sum[`MIE_DW];
    auxCarry = lowSum[4];
    overflow = (opA[`MIE_DW-1] == opB[`MIE_DW-1]) && (sum[`MIE_DW-1] != opA[`MIE_DW-1]);
    result   = (aluOp == ALU_AND) ? (opA & opB) : sum[`MIE_DW-1:0];
  end
endmodule

/* File: src/mie_consts.svh */
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH
// widths
`define MIE_DW        8
`define MIE_PC_W      11
`define MIE_ROM_W     16
`define MIE_PAGE_LSB  8
// fixed values
`define MIE_PCL_ADDR  8'h06
`define MIE_ZERO_BYTE 8'h00
`define MIE_ONES_BYTE 8'hFF
`define MIE_ONE_BYTE  8'h01
`define MIE_LAST_PAGE 3'h7
`define MIE_PC_RST    11'h000
`define MIE_PC_ONE    11'h001
`define MIE_PC_TWO    11'h002
`define MIE_ACC_RST   8'h00
`define MIE_TO_RST    1'b0
`define MIE_PDF_RST   1'b0
`endif

/* File: src/mie_exec.sv */
`timescale 1ns/100ps
`include "mie_consts.svh"
module mie_exec
  import mie_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // instruction from fetch
  input  wire logic                   instValid,
  input  wire mie_instr_s             instr,
  output logic                        instReady,
  // data memory
  input  wire logic [`MIE_DW-1:0]     memRdData,
  output mie_memwr_s                  memWr,
  // program memory table port
  output logic [`MIE_PC_W-1:0]        romAddr,
  output logic                        romRd,
  input  wire logic [`MIE_ROM_W-1:0]  romData,
  input  wire logic [`MIE_DW-1:0]     tblPtr,
  // stack
  input  wire logic [`MIE_PC_W-1:0]   stackTop,
  output mie_push_s                   push,
  output logic                        stackPop,
  // core state
  output logic [`MIE_PC_W-1:0]        pc,
  output logic [`MIE_DW-1:0]          workReg,
  output logic [`MIE_DW-1:0]          tableHighByte,
  output mie_flags_s                  flags,
  // watchdog, interrupts, power-down
  input  wire logic                   wdtTimeout,
  input  wire logic                   wakeUp,
  output logic                        wdtClear,
  output logic                        intEnableSet,
  output logic                        halted
);
  // ==========================================================
  // reset release
  logic rstMeta_q;
  logic rstSync_q;
  logic rstN;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end
  assign rstN = rstSync_q;

  // ==========================================================
  // state
  mie_state_e               state_q,   state_d;
  logic [`MIE_PC_W-1:0]     pc_q,      pc_d;
  logic [`MIE_DW-1:0]       acc_q,     acc_d;
  logic [`MIE_DW-1:0]       table_high_byte_q,    table_high_byte_d;
  logic [`MIE_DW-1:0]       tblDst_q,  tblDst_d;
  mie_flags_s               flags_q,   flags_d;
  mie_wdphase_e             wdPhase_q, wdPhase_d;
  mie_memwr_s               memWr_q,   memWr_d;
  mie_push_s                push_q,    push_d;
  logic                     pop_q,     pop_d;
  logic [`MIE_PC_W-1:0]     romAddr_q, romAddr_d;
  logic                     romRd_q,   romRd_d;
  logic                     wdtClr_q,  wdtClr_d;
  logic                     intEn_q,   intEn_d;

  logic                     take;
  logic                     skipTaken;
  logic [`MIE_DW-1:0]       memVal;
  logic [`MIE_DW-1:0]       incVal;
  logic [`MIE_DW-1:0]       decVal;
  logic [`MIE_DW-1:0]       aluB;
  logic                     aluCin;
  mie_aluop_e               aluOp;
  logic [`MIE_DW-1:0]       aluRes;
  logic                     aluC;
  logic                     aluAc;
  logic                     aluOv;

  // ==========================================================
  // operand path
  assign take      = instValid && (state_q == ST_EXEC);
  assign instReady = (state_q == ST_EXEC);
  // forward a write still in flight to the next read
  assign memVal = (memWr_q.en && memWr_q.addr == instr.addr) ? memWr_q.data : memRdData;
  assign incVal = memVal + `MIE_ONE_BYTE;
  assign decVal = memVal - `MIE_ONE_BYTE;
  assign aluB   = (instr.op == OP_ADD_I || instr.op == OP_AND_I) ? instr.imm : memVal;
  assign aluCin = (instr.op == OP_ADC || instr.op == OP_ADC_M) && flags_q.c;
  assign aluOp  = (instr.op == OP_AND || instr.op == OP_AND_M || instr.op == OP_AND_I) ? ALU_AND : ALU_ADD;

  mie_alu u_alu (
    .opA      (acc_q),
    .opB      (aluB),
    .carryIn  (aluCin),
    .aluOp    (aluOp),
    .result   (aluRes),
    .carryOut (aluC),
    .auxCarry (aluAc),
    .overflow (aluOv)
  );

  // ==========================================================
  // next state
  always_comb
  begin
    state_d   = state_q;
    pc_d      = pc_q;
    acc_d     = acc_q;
    table_high_byte_d    = table_high_byte_q;
    tblDst_d  = tblDst_q;
    flags_d   = flags_q;
    wdPhase_d = wdPhase_q;
    memWr_d   = memWr_q;
    memWr_d.en = 1'b0;
    push_d    = push_q;
    push_d.en = 1'b0;
    pop_d     = 1'b0;
    romAddr_d = romAddr_q;
    romRd_d   = 1'b0;
    wdtClr_d  = 1'b0;
    intEn_d   = 1'b0;
    skipTaken = 1'b0;
    case (state_q)
      ST_EXEC:
      begin
        if (take)
        begin
          pc_d      = pc_q + `MIE_PC_ONE;
          wdPhase_d = WD_NONE;
          memWr_d.addr = instr.addr;
          case (instr.op)
            OP_INC_SKIP, OP_INC_SKIP_W:
            begin
              if (instr.op == OP_INC_SKIP) memWr_d.en = 1'b1;
              else acc_d = incVal;
              memWr_d.data = incVal;
              skipTaken = (incVal == `MIE_ZERO_BYTE);
            end
            OP_DEC_SKIP, OP_DEC_SKIP_W:
            begin
              if (instr.op == OP_DEC_SKIP) memWr_d.en = 1'b1;
              else acc_d = decVal;
              memWr_d.data = decVal;
              skipTaken = (decVal == `MIE_ZERO_BYTE);
            end
            OP_CALL:
            begin
              push_d.en   = 1'b1;
              push_d.data = pc_q + `MIE_PC_ONE;
              pc_d        = instr.target;
              state_d     = ST_DUMMY;
            end
            OP_RET, OP_RET_IMM, OP_RET_INT:
            begin
              pop_d   = 1'b1;
              pc_d    = stackTop;
              state_d = ST_DUMMY;
              if (instr.op == OP_RET_IMM) acc_d = instr.imm;
              if (instr.op == OP_RET_INT) intEn_d = 1'b1;
            end
            OP_TBL_CUR, OP_TBL_LAST:
            begin
              romRd_d   = 1'b1;
              tblDst_d  = instr.addr;
              state_d   = ST_TABLE;
              if (instr.op == OP_TBL_CUR) romAddr_d = {pc_q[`MIE_PC_W-1:`MIE_PAGE_LSB], tblPtr};
              else romAddr_d = {`MIE_LAST_PAGE, tblPtr};
            end
            OP_CLR:
            begin
              memWr_d.en   = 1'b1;
              memWr_d.data = `MIE_ZERO_BYTE;
            end
            OP_SET:
            begin
              memWr_d.en   = 1'b1;
              memWr_d.data = `MIE_ONES_BYTE;
            end
            OP_CLR_BIT:
            begin
              memWr_d.en   = 1'b1;
              memWr_d.data = memVal & ~(`MIE_ONE_BYTE << instr.bitSel);
            end
            OP_CPL:
            begin
              memWr_d.en   = 1'b1;
              memWr_d.data = ~memVal;
              flags_d.z    = (~memVal == `MIE_ZERO_BYTE);
            end
            OP_SWAP:
            begin
              memWr_d.en   = 1'b1;
              memWr_d.data = {memVal[3:0], memVal[7:4]};
            end
            OP_SWAP_W: acc_d = {memVal[3:0], memVal[7:4]};
            OP_WDT_CLR:
            begin
              wdtClr_d    = 1'b1;
              flags_d.to  = 1'b0;
              flags_d.power_down_flag = 1'b0;
            end
            OP_WDT_ONE, OP_WDT_TWO:
            begin
              wdPhase_d = (instr.op == OP_WDT_ONE) ? WD_ONE : WD_TWO;
              if ((instr.op == OP_WDT_ONE && wdPhase_q == WD_TWO) ||
                  (instr.op == OP_WDT_TWO && wdPhase_q == WD_ONE))
              begin
                wdtClr_d    = 1'b1;
                flags_d.to  = 1'b0;
                flags_d.power_down_flag = 1'b0;
              end
            end
            OP_HALT:
            begin
              wdtClr_d    = 1'b1;
              flags_d.to  = 1'b0;
              flags_d.power_down_flag = 1'b1;
              state_d     = ST_HALT;
            end
            OP_ADC, OP_ADD, OP_ADD_I, OP_ADC_M, OP_ADD_M:
            begin
              if (instr.op == OP_ADC_M || instr.op == OP_ADD_M) memWr_d.en = 1'b1;
              else acc_d = aluRes;
              memWr_d.data = aluRes;
              flags_d.ov = aluOv;
              flags_d.z  = (aluRes == `MIE_ZERO_BYTE);
              flags_d.ac = aluAc;
              flags_d.c  = aluC;
            end
            OP_AND, OP_AND_I, OP_AND_M:
            begin
              if (instr.op == OP_AND_M) memWr_d.en = 1'b1;
              else acc_d = aluRes;
              memWr_d.data = aluRes;
              flags_d.z = (aluRes == `MIE_ZERO_BYTE);
            end
            default: ;
          endcase
          if (skipTaken)
          begin
            pc_d    = pc_q + `MIE_PC_TWO;
            state_d = ST_DUMMY;
          end
          if (memWr_d.en && memWr_d.addr == `MIE_PCL_ADDR)
          begin
            pc_d    = {pc_q[`MIE_PC_W-1:`MIE_PAGE_LSB], memWr_d.data};
            state_d = ST_DUMMY;
          end
        end
      end
      ST_DUMMY: state_d = ST_EXEC;
      ST_TABLE:
      begin
        table_high_byte_d       = romData[`MIE_ROM_W-1:`MIE_DW];
        memWr_d.en   = 1'b1;
        memWr_d.addr = tblDst_q;
        memWr_d.data = romData[`MIE_DW-1:0];
        state_d      = ST_EXEC;
      end
      ST_HALT: if (wakeUp) state_d = ST_EXEC;
      default: state_d = ST_EXEC;
    endcase
    // timeout event beats a clear in the same cycle
    if (wdtTimeout) flags_d.to = 1'b1;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_q   <= ST_EXEC;
      pc_q      <= `MIE_PC_RST;
      acc_q     <= `MIE_ACC_RST;
      table_high_byte_q    <= `MIE_ZERO_BYTE;
      tblDst_q  <= `MIE_ZERO_BYTE;
      flags_q   <= '{to: `MIE_TO_RST, power_down_flag: `MIE_PDF_RST, default: 1'b0};
      wdPhase_q <= WD_NONE;
      memWr_q   <= '0;
      push_q    <= '0;
      pop_q     <= 1'b0;
      romAddr_q <= `MIE_PC_RST;
      romRd_q   <= 1'b0;
      wdtClr_q  <= 1'b0;
      intEn_q   <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      pc_q      <= pc_d;
      acc_q     <= acc_d;
      table_high_byte_q    <= table_high_byte_d;
      tblDst_q  <= tblDst_d;
      flags_q   <= flags_d;
      wdPhase_q <= wdPhase_d;
      memWr_q   <= memWr_d;
      push_q    <= push_d;
      pop_q     <= pop_d;
      romAddr_q <= romAddr_d;
      romRd_q   <= romRd_d;
      wdtClr_q  <= wdtClr_d;
      intEn_q   <= intEn_d;
    end
  end

  assign memWr         = memWr_q;
  assign romAddr       = romAddr_q;
  assign romRd         = romRd_q;
  assign push          = push_q;
  assign stackPop      = pop_q;
  assign pc            = pc_q;
  assign workReg       = acc_q;
  assign tableHighByte = table_high_byte_q;
  assign flags         = flags_q;
  assign wdtClear      = wdtClr_q;
  assign intEnableSet  = intEn_q;
  assign halted        = (state_q == ST_HALT);

  // ==========================================================
  // checks
  sequence s_dummyThenExec;
    state_q == ST_DUMMY ##1 state_q == ST_EXEC;
  endsequence

  property p_skipTwoCycles;
    @(posedge clk) disable iff (!rstN)
      take && skipTaken && !(memWr_d.en && memWr_d.addr == `MIE_PCL_ADDR) |=> s_dummyThenExec;
  endproperty
  a_skipTwoCycles: assert property (p_skipTwoCycles) else $error("taken skip not two cycles");

  property p_noSkipOneCycle;
    @(posedge clk) disable iff (!rstN)
      take && (instr.op == OP_SWAP_W || instr.op == OP_INC_SKIP_W) && !skipTaken |=> instReady;
  endproperty
  a_noSkipOneCycle: assert property (p_noSkipOneCycle) else $error("single cycle op stalled");

  property p_pclWrite;
    @(posedge clk) disable iff (!rstN)
      take && memWr_d.en && memWr_d.addr == `MIE_PCL_ADDR |=> s_dummyThenExec and pc_q[`MIE_DW-1:0] == memWr_q.data;
  endproperty
  a_pclWrite: assert property (p_pclWrite) else $error("pcl write not two cycles");

  property p_wdtPair;
    @(posedge clk) disable iff (!rstN)
      take && instr.op == OP_WDT_TWO && wdPhase_q == WD_ONE && !wdtTimeout |=> !flags_q.to && !flags_q.power_down_flag && wdtClear;
  endproperty
  a_wdtPair: assert property (p_wdtPair) else $error("pre-clear pair did not clear");

  property p_wdtRepeat;
    @(posedge clk) disable iff (!rstN)
      take && instr.op == OP_WDT_ONE && wdPhase_q != WD_TWO |=> !wdtClear && $stable(flags_q.power_down_flag);
  endproperty
  a_wdtRepeat: assert property (p_wdtRepeat) else $error("lone pre-clear had effect");

  property p_wdtSingle;
    @(posedge clk) disable iff (!rstN)
      take && instr.op == OP_WDT_CLR && !wdtTimeout |=> wdtClear && !flags_q.to && !flags_q.power_down_flag
        ##1 ($past(take) || !wdtClear);
  endproperty
  a_wdtSingle: assert property (p_wdtSingle) else $error("watchdog clear wrong");

  property p_call;
    @(posedge clk) disable iff (!rstN)
      take && instr.op == OP_CALL |=> push.en && push.data == $past(pc_q) + `MIE_PC_ONE
        && pc_q == $past(instr.target) ##1 instReady;
  endproperty
  a_call: assert property (p_call) else $error("call wrong");

  property p_return;
    @(posedge clk) disable iff (!rstN)
      take && (instr.op == OP_RET || instr.op == OP_RET_IMM || instr.op == OP_RET_INT)
        |=> stackPop && pc_q == $past(stackTop)
        && $stable({flags_q.power_down_flag, flags_q.ov, flags_q.z, flags_q.ac, flags_q.c}) ##1 instReady;
  endproperty
  a_return: assert property (p_return) else $error("return wrong");

  sequence s_tableFill;
    state_q == ST_TABLE && romRd ##1 memWr.en && tableHighByte == $past(romData[`MIE_ROM_W-1:`MIE_DW]);
  endsequence

  property p_tableRead;
    @(posedge clk) disable iff (!rstN)
      take && (instr.op == OP_TBL_CUR || instr.op == OP_TBL_LAST) |=> s_tableFill ##0 instReady;
  endproperty
  a_tableRead: assert property (p_tableRead) else $error("table read wrong");

  property p_halt;
    @(posedge clk) disable iff (!rstN)
      take && instr.op == OP_HALT && !wdtTimeout |=> halted && flags_q.power_down_flag && !flags_q.to && wdtClear;
  endproperty
  a_halt: assert property (p_halt) else $error("power-down entry wrong");

  property p_clear;
    @(posedge clk) disable iff (!rstN)
      take && instr.op == OP_CLR |=> memWr.en && memWr.data == `MIE_ZERO_BYTE && $stable(flags_q.z);
  endproperty
  a_clear: assert property (p_clear) else $error("clear wrong");

  property p_andImm;
    @(posedge clk) disable iff (!rstN)
      take && instr.op == OP_AND_I |=> workReg == ($past(acc_q) & $past(instr.imm)) && $stable(flags_q.c);
  endproperty
  a_andImm: assert property (p_andImm) else $error("and result wrong");
endmodule

/* File: src/mie_pkg.sv */
`include "mie_consts.svh"
package mie_pkg;
  // decoded operations of this execute slice
  typedef enum logic [4:0] {
    OP_NOP, OP_INC_SKIP, OP_INC_SKIP_W, OP_DEC_SKIP, OP_DEC_SKIP_W,
    OP_CALL, OP_RET, OP_RET_IMM, OP_RET_INT, OP_TBL_CUR, OP_TBL_LAST,
    OP_CLR, OP_SET, OP_CLR_BIT, OP_CPL, OP_SWAP, OP_SWAP_W,
    OP_WDT_CLR, OP_WDT_ONE, OP_WDT_TWO, OP_HALT,
    OP_ADC, OP_ADC_M, OP_ADD, OP_ADD_M, OP_ADD_I, OP_AND, OP_AND_M, OP_AND_I
  } mie_op_e;

  typedef enum logic [3:0] {
    ST_EXEC  = 4'h1,
    ST_DUMMY = 4'h2,
    ST_TABLE = 4'h4,
    ST_HALT  = 4'h8
  } mie_state_e;

  typedef enum logic [1:0] {WD_NONE = 2'h0, WD_ONE = 2'h1, WD_TWO = 2'h2} mie_wdphase_e;
  typedef enum logic {ALU_ADD = 1'b0, ALU_AND = 1'b1} mie_aluop_e;

  typedef struct packed {
    mie_op_e                 op;
    logic [`MIE_DW-1:0]      addr;
    logic [`MIE_DW-1:0]      imm;
    logic [2:0]              bitSel;
    logic [`MIE_PC_W-1:0]    target;
  } mie_instr_s;

  typedef struct packed {
    logic                    en;
    logic [`MIE_DW-1:0]      addr;
    logic [`MIE_DW-1:0]      data;
  } mie_memwr_s;

  typedef struct packed {
    logic                    en;
    logic [`MIE_PC_W-1:0]    data;
  } mie_push_s;

  typedef struct packed {
    logic to;
    logic power_down_flag;
    logic ov;
    logic z;
    logic ac;
    logic c;
  } mie_flags_s;
endpackage

/* File: test/mie_core_model.sv */
`timescale 1ns/100ps
`include "mie_consts.svh"
module mie_core_model
  import mie_pkg::*;
(
  // clock
  input  wire logic         clk,
  // data memory
  input  wire logic [7:0]   rdAddr,
  input  wire mie_memwr_s   memWr,
  output logic [7:0]        memRdData,
  // program memory
  input  wire logic [10:0]  romAddr,
  input  wire logic         romRd,
  output logic [15:0]       romData,
  // stack
  input  wire mie_push_s    push,
  input  wire logic         stackPop,
  output logic [10:0]       stackTop
);
  logic [7:0]   mem [256];
  logic [10:0]  stk [8];
  logic [2:0]   sp = 3'h0;
  logic [15:0]  romLast = 16'h0000;

  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
  end

  // word outside its read slot shows inverted junk
  // word valid in the cycle that romRd stands, as the exec unit samples it then
  assign romData   = romRd ? {romAddr[7:0] ^ 8'h5A, romAddr[7:0]} : ~romLast;
  assign memRdData = mem[rdAddr];
  assign stackTop  = stk[sp - 3'h1];

  always @(posedge clk)
  begin
    if (romRd)
      romLast <= romData;
    if (memWr.en)
      mem[memWr.addr] <= memWr.data;
    if (push.en)
    begin
      stk[sp] <= push.data;
      sp      <= sp + 3'h1;
    end
    else if (stackPop)
      sp <= sp - 3'h1;
  end
endmodule

/* File: test/testbench.sv */
`timescale 1ns/100ps
`include "mie_consts.svh"
`define CHK(a, e) begin samplesChecked++; if ((a) !== (e)) begin errorCnt++; \
  $display("mismatch at %0t got %0h exp %0h", $time, (a), (e)); end end
module testbench
  import mie_pkg::*;
;
  logic         clk = 1'b0;
  logic         arstN = 1'b0;
  logic         instValid = 1'b0;
  mie_instr_s   instr = '0;
  logic         instReady;
  logic [7:0]   memRdData;
  mie_memwr_s   memWr;
  logic [10:0]  romAddr;
  logic         romRd;
  logic [15:0]  romData;
  logic [7:0]   tblPtr = 8'h44;
  logic [10:0]  stackTop;
  mie_push_s    push;
  logic         stackPop;
  logic [10:0]  pc;
  logic [7:0]   workReg;
  logic [7:0]   tableHighByte;
  mie_flags_s   flags;
  logic         wdtTimeout = 1'b0;
  logic         wakeUp = 1'b0;
  logic         wdtClear;
  logic         intEnableSet;
  logic         halted;
  int           errorCnt = 0;
  int           samplesChecked = 0;
  logic [10:0]  epc = 11'h000;
  logic [10:0]  r;
  logic [7:0]   ew = 8'h00;
  logic [7:0]   res;
  mie_flags_s   ef = '0;
  mie_op_e      rets [3];

  always #50 clk = ~clk;

  mie_exec i_dut (.clk(clk), .arst_n(arstN), .instValid(instValid), .instr(instr), .instReady(instReady),
    .memRdData(memRdData), .memWr(memWr), .romAddr(romAddr), .romRd(romRd), .romData(romData),
    .tblPtr(tblPtr), .stackTop(stackTop), .push(push), .stackPop(stackPop), .pc(pc), .workReg(workReg),
    .tableHighByte(tableHighByte), .flags(flags), .wdtTimeout(wdtTimeout), .wakeUp(wakeUp),
    .wdtClear(wdtClear), .intEnableSet(intEnableSet), .halted(halted));

  mie_core_model i_mem (.clk(clk), .rdAddr(instr.addr), .memWr(memWr), .memRdData(memRdData),
    .romAddr(romAddr), .romRd(romRd), .romData(romData), .push(push), .stackPop(stackPop),
    .stackTop(stackTop));

  // ==========================================
  // helpers
  function automatic logic [11:0] addx(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
    return {(a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 8'h00, h[4], s[8], s[7:0]};
  endfunction

  task automatic ex(input mie_op_e op, input logic [7:0] a = 8'h20, input logic [7:0] im = 8'h00,
                    input logic [2:0] b = 3'h0, input logic [10:0] tg = 11'h000);
    int n;
    n = 0;
    instValid = 1'b1;
    instr = '{op, a, im, b, tg};
    while (!instReady && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    // never accepted: count it rather than run on silently
    if (!instReady)
      errorCnt++;
    @(negedge clk);
    epc = epc + 11'h001;
  endtask

  task automatic idle();
    instValid = 1'b0;
    @(negedge clk);
  endtask

  task automatic tout();
    wdtTimeout = 1'b1;
    @(negedge clk);
    wdtTimeout = 1'b0;
    ef.to = 1'b1;
  endtask

  task automatic chkSt();
    `CHK(workReg, ew)
    `CHK(flags, ef)
    `CHK(pc, epc)
  endtask

  // v is the immediate or the known memory operand
  task automatic alu(input mie_op_e op, input logic [7:0] v, input logic useC);
    ex(op, 8'h20, v);
    if (op inside {OP_AND, OP_AND_M, OP_AND_I})
    begin
      res = ew & v;
      ef.z = (res == 8'h00);
    end
    else
      {ef.ov, ef.z, ef.ac, ef.c, res} = addx(ew, v, useC & ef.c);
    if (op inside {OP_ADC_M, OP_ADD_M, OP_AND_M})
      `CHK(memWr.data, res)
    else
      ew = res;
    chkSt();
  endtask

  task automatic endOfTest();
    $display("comparisons %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #(100 * 2000);
    errorCnt++;
    endOfTest();
  end

  // ==========================================
  // tests
  initial
  begin
    repeat (8) @(negedge clk);
    arstN = 1'b1;
    repeat (3) @(negedge clk);
    chkSt();
    ex(OP_SET);
    `CHK(memWr, {1'b1, 8'h20, 8'hFF})
    ex(OP_CLR_BIT, 8'h20, 8'h00, 3'h3);
    `CHK(memWr, {1'b1, 8'h20, 8'hF7})
    ex(OP_CPL);
    `CHK(memWr.data, 8'h08)
    ex(OP_SWAP_W);
    ew = 8'h80;
    chkSt();
    ex(OP_SWAP);
    `CHK(memWr.data, 8'h80)
    ex(OP_CLR);
    `CHK(memWr.data, 8'h00)
    chkSt();
    ex(OP_INC_SKIP_W);
    ew = 8'h01;
    chkSt();
    `CHK({memWr.en, instReady}, 2'b01)
    ex(OP_DEC_SKIP_W);
    ew = 8'hFF;
    chkSt();
    ex(OP_INC_SKIP);
    `CHK(memWr.data, 8'h01)
    ex(OP_DEC_SKIP);
    epc = epc + 11'h001;
    `CHK(memWr.data, 8'h00)
    chkSt();
    `CHK(instReady, 1'b0)
    ex(OP_SET);
    ex(OP_INC_SKIP);
    epc = epc + 11'h001;
    chkSt();
    `CHK(instReady, 1'b0)
    alu(OP_ADD_I, 8'h01, 1'b0);
    alu(OP_ADC, 8'h00, 1'b1);
    alu(OP_ADD_I, 8'h7F, 1'b0);
    alu(OP_ADD_M, 8'h00, 1'b0);
    alu(OP_ADC_M, 8'h80, 1'b1);
    alu(OP_AND_I, 8'h0F, 1'b0);
    alu(OP_ADD, 8'h00, 1'b0);
    alu(OP_ADD_I, 8'h3C, 1'b0);
    alu(OP_AND_M, 8'h00, 1'b0);
    alu(OP_AND, 8'h00, 1'b0);
    idle();
    tout();
    ex(OP_WDT_ONE);
    chkSt();
    ex(OP_WDT_ONE);
    chkSt();
    ex(OP_WDT_TWO);
    ef.to = 1'b0;
    chkSt();
    `CHK(wdtClear, 1'b1)
    idle();
    tout();
    ex(OP_WDT_TWO);
    ex(OP_NOP);
    ex(OP_WDT_ONE);
    chkSt();
    `CHK(wdtClear, 1'b0)
    r = epc + 11'h001;
    ex(OP_CALL, 8'h00, 8'h00, 3'h0, 11'h523);
    epc = 11'h523;
    `CHK(push, {1'b1, r})
    `CHK({pc, instReady}, {epc, 1'b0})
    ex(OP_TBL_CUR, 8'h30);
    `CHK({romRd, romAddr, instReady}, {1'b1, 3'h5, 8'h44, 1'b0})
    idle();
    `CHK({memWr, tableHighByte}, {1'b1, 8'h30, 8'h44, 8'h1E})
    tblPtr = 8'h9C;
    ex(OP_TBL_LAST, 8'h31);
    `CHK({romRd, romAddr, instReady}, {1'b1, 3'h7, 8'h9C, 1'b0})
    idle();
    `CHK({memWr, tableHighByte}, {1'b1, 8'h31, 8'h9C, 8'hC6})
    ex(OP_CLR, 8'h06);
    epc = 11'h500;
    `CHK({pc, instReady}, {epc, 1'b0})
    rets = '{OP_RET, OP_RET_IMM, OP_RET_INT};
    foreach (rets[i])
    begin
      r = epc + 11'h001;
      ex(OP_CALL, 8'h00, 8'h00, 3'h0, 11'h300);
      `CHK(push, {1'b1, r})
      epc = 11'h300;
      ex(rets[i], 8'h00, 8'hA5);
      if (rets[i] == OP_RET_IMM)
        ew = 8'hA5;
      epc = r;
      chkSt();
      `CHK({stackPop, instReady}, 2'b10)
      `CHK(intEnableSet, rets[i] == OP_RET_INT)
    end
    idle();
    tout();
    ex(OP_HALT);
    ef.to = 1'b0;
    ef.power_down_flag = 1'b1;
    chkSt();
    `CHK({halted, wdtClear, instReady}, 3'b110)
    idle();
    idle();
    `CHK({halted, instReady, workReg, pc}, {2'b10, ew, epc})
    wakeUp = 1'b1;
    @(negedge clk);
    wakeUp = 1'b0;
    `CHK({halted, instReady}, 2'b01)
    ex(OP_WDT_CLR);
    ef.power_down_flag = 1'b0;
    chkSt();
    `CHK(wdtClear, 1'b1)
    idle();
    endOfTest();
  end
endmodule
